// [verilog/speed_deviation_supervisor.sv]
// Speed deviation supervisor with stop and zero-speed handling
//
// How it works
// - Deviation is the magnitude of measured speed minus reference
// - Deviation settings refused while drive runs
// - Deviation select 0..7, default 3
// - Selects 0..3 qualify on output frequency match
// - Selects 4..7 qualify on encoder speed match
// - Select picks decel, coast, fast stop, alarm
// - Threshold 0..50 percent of max, default 10
// - Fault after deviation persists for set time
// - Flux vector keeps running below minimum frequency, except zero-speed 1
// - Stop method picks decel, coast, brake, timer
// - Flux vector rejects stop methods 2, 3
// - Zero-speed 0 follows reference directly
// - Zero-speed 1 cuts output below minimum
// - Zero-speed 2 outputs minimum below minimum
// - Zero-speed 3 substitutes zero below minimum
// - Minimum frequency 0.0..400.0, default 0.0
//
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module speed_deviation_supervisor #(
  parameter int TICK_CYCLES = speed_dev_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  // Avalon-MM slave
  input  wire logic [5:0]                 avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic [31:0]                     avs_readdata,
  output logic                            avs_waitrequest,
  // Drive state
  input  wire logic                       drive_running,
  input  wire logic                       flux_vector_mode,
  input  wire logic                       stop_command,
  // Speeds in 0.1 Hz
  input  wire logic [15:0]                freq_reference,
  input  wire logic [15:0]                output_frequency,
  input  wire logic [15:0]                motor_speed,
  // Responses
  output logic                            speed_deviation_fault,
  output logic                            speed_deviation_alarm,
  output speed_dev_pkg::action_type       drive_action,
  output logic [15:0]                     freq_command,
  output logic                            output_cut,
  output logic                            irq
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
    abs_diff = (a >= b) ? a - b : b - a;
  endfunction

  function automatic logic [31:0] lane_mix(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    lane_mix = (old & ~m) | (wd & m);
  endfunction

  localparam int NUM_ST = speed_dev_pkg::NUM_ST;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [2:0]        sel_q;
  logic [1:0]        stop_q;
  logic [1:0]        zero_q;
  logic [5:0]        level_q;
  logic [6:0]        time_q;
  logic [11:0]       minf_q;
  logic [11:0]       maxf_q;
  logic [11:0]       band_q;
  logic [NUM_ST-1:0] status_q;
  logic [NUM_ST-1:0] mask_q;
  logic              ack_q;
  logic [31:0]       rdata_q;
  logic              exp_q;
  speed_dev_pkg::action_type fault_act_q;
  speed_dev_pkg::action_type act_q;
  speed_dev_pkg::action_type act_d;
  logic [15:0]       fcmd_q;
  logic [15:0]       fcmd_d;
  logic              cut_q;
  logic              cut_d;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic        req;
  logic        wr_fire;
  logic [31:0] cfg_word;
  logic [31:0] cfg_new;
  logic [31:0] lvl_new;
  logic [31:0] tim_new;
  logic [31:0] minf_new;
  logic [31:0] maxf_new;
  logic [31:0] band_new;
  logic [31:0] rd_mux;
  logic        hit_cfg;
  logic        hit_lvl;
  logic        hit_tim;
  logic        hit_minf;
  logic        hit_maxf;
  logic        hit_band;
  logic        hit_st;
  logic        hit_mask;
  logic        bad_cfg;
  logic        bad_lvl;
  logic        bad_tim;
  logic        bad_minf;
  logic        refuse_ev;

  // One wait cycle, then the access completes
  assign req             = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_q;
  assign wr_fire         = avs_write && ack_q;
  assign avs_readdata    = rdata_q;

  // Address hits on the completing write
  assign hit_cfg  = wr_fire && (avs_address == speed_dev_pkg::OFS_CONFIG);
  assign hit_lvl  = wr_fire && (avs_address == speed_dev_pkg::OFS_DEV_LEVEL);
  assign hit_tim  = wr_fire && (avs_address == speed_dev_pkg::OFS_DEV_TIME);
  assign hit_minf = wr_fire && (avs_address == speed_dev_pkg::OFS_MIN_FREQ);
  assign hit_maxf = wr_fire && (avs_address == speed_dev_pkg::OFS_MAX_FREQ);
  assign hit_band = wr_fire && (avs_address == speed_dev_pkg::OFS_BAND);
  assign hit_st   = wr_fire && (avs_address == speed_dev_pkg::OFS_STATUS);
  assign hit_mask = wr_fire && (avs_address == speed_dev_pkg::OFS_MASK);

  // Candidate values after byte lanes are merged
  assign cfg_word = 32'({zero_q, 2'h0, stop_q, 1'h0, sel_q});
  assign cfg_new  = lane_mix(cfg_word, avs_writedata, avs_byteenable);
  assign lvl_new  = lane_mix(32'(level_q), avs_writedata, avs_byteenable);
  assign tim_new  = lane_mix(32'(time_q), avs_writedata, avs_byteenable);
  assign minf_new = lane_mix(32'(minf_q), avs_writedata, avs_byteenable);
  assign maxf_new = lane_mix(32'(maxf_q), avs_writedata, avs_byteenable);
  assign band_new = lane_mix(32'(band_q), avs_writedata, avs_byteenable);

  assign bad_cfg = (drive_running && ((cfg_new[speed_dev_pkg::SEL_LSB +: 3] != sel_q) ||
                                      (cfg_new[speed_dev_pkg::ZERO_LSB +: 2] != zero_q))) ||
                   (flux_vector_mode && cfg_new[speed_dev_pkg::STOP_LSB + 1]);
  assign bad_lvl  = drive_running || (lvl_new > 32'(speed_dev_pkg::LEVEL_MAX));
  assign bad_tim  = drive_running || (tim_new > 32'(speed_dev_pkg::TIME_MAX));
  assign bad_minf = drive_running || (minf_new > 32'(speed_dev_pkg::MINF_MAX));

  assign refuse_ev = (hit_cfg && bad_cfg) || (hit_lvl && bad_lvl) ||
                     (hit_tim && bad_tim) || (hit_minf && bad_minf);

  // Bus handshake and read capture
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q   <= req && !ack_q;
      rdata_q <= (avs_read && !ack_q) ? rd_mux : rdata_q;
    end
  end

  // Settings registers
  // select default 3
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_q   <= speed_dev_pkg::SEL_RST;
      stop_q  <= speed_dev_pkg::STOP_RST;
      zero_q  <= speed_dev_pkg::ZERO_RST;
      level_q <= speed_dev_pkg::LEVEL_RST;
      time_q  <= speed_dev_pkg::TIME_RST;
      minf_q  <= speed_dev_pkg::MINF_RST;
      maxf_q  <= speed_dev_pkg::MAXF_RST;
      band_q  <= speed_dev_pkg::BAND_RST;
      mask_q  <= {NUM_ST{1'b0}};
    end else begin
      if (hit_cfg && !bad_cfg) begin
        sel_q  <= cfg_new[speed_dev_pkg::SEL_LSB +: 3];
        stop_q <= cfg_new[speed_dev_pkg::STOP_LSB +: 2];
        zero_q <= cfg_new[speed_dev_pkg::ZERO_LSB +: 2];
      end
      if (hit_lvl && !bad_lvl) begin
        level_q <= lvl_new[5:0];
      end
      if (hit_tim && !bad_tim) begin
        time_q <= tim_new[6:0];
      end
      if (hit_minf && !bad_minf) begin
        minf_q <= minf_new[11:0];
      end
      if (hit_maxf) begin
        maxf_q <= maxf_new[11:0];
      end
      if (hit_band) begin
        band_q <= band_new[11:0];
      end
      if (hit_mask) begin
        mask_q <= avs_writedata[NUM_ST-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Deviation detection
  // ---------------------------------------------------------------
  logic [15:0] dev_mag;
  logic [15:0] match_err;
  logic        ref_match;
  logic        over_lvl;
  logic        persist_on;
  logic        expired;
  logic        expire_ev;
  logic        fault_ev;
  logic        alarm_ev;

  assign dev_mag = abs_diff(motor_speed, freq_reference);

  assign match_err = sel_q[2] ? abs_diff(freq_reference, motor_speed)
                              : abs_diff(freq_reference, output_frequency);
  assign ref_match = drive_running && (match_err <= 16'(band_q));

  assign over_lvl = (24'(dev_mag) * speed_dev_pkg::PERCENT) > (24'(maxf_q) * 24'(level_q));

  assign persist_on = ref_match && over_lvl;

  persist_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .active  (persist_on),
    .limit   (time_q),
    .expired (expired)
  );

  assign expire_ev = expired && !exp_q;
  assign alarm_ev  = expire_ev && (sel_q[1:0] == 2'h3);
  assign fault_ev  = expire_ev && (sel_q[1:0] != 2'h3);

  // ---------------------------------------------------------------
  // Status and interrupt
  // ---------------------------------------------------------------
  logic [NUM_ST-1:0] st_set;

  assign st_set[speed_dev_pkg::ST_FAULT]  = fault_ev;
  assign st_set[speed_dev_pkg::ST_ALARM]  = alarm_ev;
  assign st_set[speed_dev_pkg::ST_REFUSE] = refuse_ev;

  // Sticky bits, set wins over write-one-to-clear
  genvar gi;
  generate
    for (gi = 0; gi < NUM_ST; gi = gi + 1) begin : g_st
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          status_q[gi] <= 1'b0;
        end else if (st_set[gi]) begin
          status_q[gi] <= 1'b1;
        end else if (hit_st && avs_byteenable[0] && avs_writedata[gi]) begin
          status_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq                   = |(status_q & mask_q);
  assign speed_deviation_fault = status_q[speed_dev_pkg::ST_FAULT];
  assign speed_deviation_alarm = status_q[speed_dev_pkg::ST_ALARM];

  // ---------------------------------------------------------------
  // Stop and zero-speed handling
  // ---------------------------------------------------------------
  speed_dev_pkg::action_type sel_act;
  speed_dev_pkg::action_type stop_act;
  logic                      below_min;

  always_comb begin
    case (sel_q[1:0])
      2'h0:    sel_act = speed_dev_pkg::ACT_DECEL;
      2'h1:    sel_act = speed_dev_pkg::ACT_COAST;
      2'h2:    sel_act = speed_dev_pkg::ACT_FAST_STOP;
      default: sel_act = speed_dev_pkg::ACT_RUN;
    endcase
  end

  always_comb begin
    case (stop_q)
      2'h0:    stop_act = speed_dev_pkg::ACT_DECEL;
      2'h1:    stop_act = speed_dev_pkg::ACT_COAST;
      2'h2:    stop_act = speed_dev_pkg::ACT_DC_BRAKE;
      2'h3:    stop_act = speed_dev_pkg::ACT_COAST_TIMER;
      default: stop_act = speed_dev_pkg::ACT_DECEL;
    endcase
  end

  // A latched fault response overrides a plain stop
  assign act_d = speed_deviation_fault ? fault_act_q :
                 (stop_command ? stop_act : speed_dev_pkg::ACT_RUN);

  assign below_min = freq_reference < 16'(minf_q);

  // Frequency command near the minimum
  always_comb begin
    fcmd_d = freq_reference;
    cut_d  = 1'b0;
    if (!flux_vector_mode) begin
      fcmd_d = below_min ? 16'h0000 : freq_reference;
      cut_d  = below_min;
    end else begin
      case (zero_q)
        2'h0: begin
          fcmd_d = freq_reference;
        end
        2'h1: begin
          fcmd_d = below_min ? 16'h0000 : freq_reference;
          cut_d  = below_min;
        end
        2'h2: begin
          fcmd_d = below_min ? 16'(minf_q) : freq_reference;
        end
        default: begin
          fcmd_d = below_min ? 16'h0000 : freq_reference;
        end
      endcase
    end
  end

  // Response registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      exp_q       <= 1'b0;
      fault_act_q <= speed_dev_pkg::ACT_RUN;
      act_q       <= speed_dev_pkg::ACT_RUN;
      fcmd_q      <= 16'h0000;
      cut_q       <= 1'b1;
    end else begin
      exp_q       <= expired;
      fault_act_q <= fault_ev ? sel_act : fault_act_q;
      act_q       <= act_d;
      fcmd_q      <= fcmd_d;
      cut_q       <= cut_d;
    end
  end

  assign drive_action = act_q;
  assign freq_command = fcmd_q;
  assign output_cut   = cut_q;

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  always_comb begin
    case (avs_address)
      speed_dev_pkg::OFS_CONFIG:    rd_mux = cfg_word;
      speed_dev_pkg::OFS_DEV_LEVEL: rd_mux = 32'(level_q);
      speed_dev_pkg::OFS_DEV_TIME:  rd_mux = 32'(time_q);
      speed_dev_pkg::OFS_MIN_FREQ:  rd_mux = 32'(minf_q);
      speed_dev_pkg::OFS_MAX_FREQ:  rd_mux = 32'(maxf_q);
      speed_dev_pkg::OFS_BAND:      rd_mux = 32'(band_q);
      speed_dev_pkg::OFS_STATUS:    rd_mux = 32'(status_q);
      speed_dev_pkg::OFS_MASK:      rd_mux = 32'(mask_q);
      speed_dev_pkg::OFS_MONITOR: begin
        rd_mux = 32'(dev_mag);
        rd_mux[speed_dev_pkg::MON_MATCH] = ref_match;
        rd_mux[speed_dev_pkg::MON_EXP]   = expired;
        rd_mux[speed_dev_pkg::MON_ACT +: 3] = act_q;
      end
      default: rd_mux = 32'h00000000;
    endcase
  end
endmodule
`default_nettype wire

// [verilog/speed_dev_pkg.sv]
// Constants and types shared by the speed deviation supervisor
package speed_dev_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [5:0] OFS_CONFIG    = 6'h00;
  localparam logic [5:0] OFS_DEV_LEVEL = 6'h04;
  localparam logic [5:0] OFS_DEV_TIME  = 6'h08;
  localparam logic [5:0] OFS_MIN_FREQ  = 6'h0C;
  localparam logic [5:0] OFS_MAX_FREQ  = 6'h10;
  localparam logic [5:0] OFS_BAND      = 6'h14;
  localparam logic [5:0] OFS_STATUS    = 6'h18;
  localparam logic [5:0] OFS_MASK      = 6'h1C;
  localparam logic [5:0] OFS_MONITOR   = 6'h20;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SEL_LSB   = 0;  // deviation_select, 3 bits
  localparam int STOP_LSB  = 4;  // stop_method_select, 2 bits
  localparam int ZERO_LSB  = 8;  // zero_speed_method, 2 bits
  localparam int ST_FAULT  = 0;
  localparam int ST_ALARM  = 1;
  localparam int ST_REFUSE = 2;
  localparam int NUM_ST    = 3;
  localparam int MON_MATCH = 16;
  localparam int MON_EXP   = 17;
  localparam int MON_ACT   = 20;

  // ---------------------------------------------------------------
  // Reset values and limits (frequencies in 0.1 Hz, time in 0.1 s)
  // ---------------------------------------------------------------
  localparam logic [2:0]  SEL_RST   = 3'h3;
  localparam logic [1:0]  STOP_RST  = 2'h0;
  localparam logic [1:0]  ZERO_RST  = 2'h0;
  localparam logic [5:0]  LEVEL_RST = 6'h0A;    // 10 percent
  localparam logic [5:0]  LEVEL_MAX = 6'h32;    // 50 percent
  localparam logic [6:0]  TIME_RST  = 7'h05;    // 0.5 s
  localparam logic [6:0]  TIME_MAX  = 7'h64;    // 10.0 s
  localparam logic [11:0] MINF_RST  = 12'h000;  // 0.0 Hz
  localparam logic [11:0] MINF_MAX  = 12'hFA0;  // 400.0 Hz
  localparam logic [11:0] MAXF_RST  = 12'h258;  // 60.0 Hz
  localparam logic [11:0] BAND_RST  = 12'h014;  // 2.0 Hz
  localparam logic [23:0] PERCENT   = 24'h000064;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_TIME_NS  = 100_000_000;  // 0.1 s time unit
  localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Drive actions
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ACT_RUN,
    ACT_DECEL,
    ACT_COAST,
    ACT_FAST_STOP,
    ACT_DC_BRAKE,
    ACT_COAST_TIMER
  } action_type;
endpackage

// [verilog/persist_timer.sv]
// Persistence timer counting whole 0.1 s units while a condition holds
`timescale 1ns/1ps
`default_nettype none
module persist_timer #(
  parameter int TICK_CYCLES = speed_dev_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Condition and limit
  input  wire logic       active,
  input  wire logic [6:0] limit,
  // Result
  output logic            expired
);
  logic [19:0] pre_q;
  logic [19:0] pre_d;
  logic [6:0]  cnt_q;
  logic [6:0]  cnt_d;
  logic        wrap;

  // Prescaler wrap marks one elapsed time unit
  assign wrap    = (pre_q == 20'(TICK_CYCLES - 1));
  assign expired = active && (cnt_q >= limit);

  assign pre_d = (!active || expired) ? 20'h00000 : (wrap ? 20'h00000 : pre_q + 20'h00001);
  assign cnt_d = !active ? 7'h00 : ((wrap && !expired) ? cnt_q + 7'h01 : cnt_q);

  // Counter registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 20'h00000;
      cnt_q <= 7'h00;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// [dv/speed_dev_props.sv]
// Bus, fault and action checks for the speed deviation supervisor
`timescale 1ns/1ps
`default_nettype none
module speed_dev_props #(
  parameter int TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Register bus
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Drive state and speeds
  input wire logic        drive_running,
  input wire logic        flux_vector_mode,
  input wire logic        stop_command,
  input wire logic [15:0] freq_reference,
  input wire logic [15:0] output_frequency,
  input wire logic [15:0] motor_speed,
  // Responses
  input wire logic        speed_deviation_fault,
  input wire logic        speed_deviation_alarm,
  input wire logic [2:0]  drive_action,
  input wire logic [15:0] freq_command,
  input wire logic        output_cut,
  input wire logic        irq
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------------------------
  // Decodes
  // ---------------------------------------------------------------
  wire req     = avs_read | avs_write;
  wire clr_any = avs_write & ~avs_waitrequest & (avs_address == speed_dev_pkg::OFS_STATUS) & avs_byteenable[0];
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  chk_wait_first: assert property ($rose(req) |-> avs_waitrequest) else $error("no wait cycle on new access");
  chk_one_wait: assert property (req && avs_waitrequest |=> !avs_waitrequest) else $error("access not done in two");
  chk_idle_ready: assert property (!req |-> !avs_waitrequest) else $error("wait raised while idle");
  chk_read_hold: assert property ($changed(avs_readdata) |-> $past(avs_read)) else $error("read data moved");
  chk_fault_clear: assert property ($fell(speed_deviation_fault) |-> $past(clr_any && avs_writedata[0]))
    else $error("fault dropped without clear");
  chk_alarm_clear: assert property ($fell(speed_deviation_alarm) |-> $past(clr_any && avs_writedata[1]))
    else $error("alarm dropped without clear");
  chk_fault_running: assert property ($rose(speed_deviation_fault) |-> $past(drive_running))
    else $error("fault raised while stopped");
  chk_fault_action: assert property (speed_deviation_fault ##1 speed_deviation_fault |->
    drive_action inside {speed_dev_pkg::ACT_DECEL, speed_dev_pkg::ACT_COAST, speed_dev_pkg::ACT_FAST_STOP})
    else $error("fault action not a stop");
  chk_run_idle: assert property ((!speed_deviation_fault && !stop_command)[*2] |->
    drive_action == speed_dev_pkg::ACT_RUN) else $error("action not run when idle");
  // Main scenarios seen
  cov_fault: cover property ($rose(speed_deviation_fault));
  cov_alarm: cover property ($rose(speed_deviation_alarm));
  cov_stop: cover property (stop_command && drive_action != speed_dev_pkg::ACT_RUN);
  cov_irq: cover property ($rose(irq));
endmodule
bind speed_deviation_supervisor speed_dev_props #(.TICK_CYCLES(TICK_CYCLES)) props (.*);
`default_nettype wire

// [dv/motor_model.sv]
// Motor with encoder feedback facing the supervisor
`timescale 1ns/1ps
`default_nettype none
module motor_model (
  // Drive side
  input  wire logic [15:0] freq_command,
  input  wire logic        output_cut,
  // Load disturbance in 0.1 Hz
  input  wire logic [15:0] slip,
  // Measured speeds
  output logic [15:0]      output_frequency,
  output logic [15:0]      motor_speed
);
  // Interrupted output leaves no frequency; the shaft leads the output frequency by the slip
  assign output_frequency = output_cut ? 16'h0000 : freq_command;
  assign motor_speed      = output_frequency + slip;
endmodule
`default_nettype wire

// [dv/tb_speed_deviation_supervisor.sv]
// Self-checking bench for the speed deviation supervisor
`timescale 1ns/1ps
`default_nettype none
module tb_speed_deviation_supervisor;
  localparam int TICK = 4;
  localparam logic [5:0]  RA [9] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h24};
  localparam logic [31:0] RV [9] = '{32'h3, 32'hA, 32'h5, 32'h0, 32'h258, 32'h14, 32'h0, 32'h0, 32'h0};
  localparam logic [2:0]  FA [4] = '{3'h1, 3'h2, 3'h3, 3'h0};  // decel, coast, fast stop, run
  localparam logic [2:0]  SA [4] = '{3'h1, 3'h2, 3'h4, 3'h5};  // decel, coast, brake, timer
  localparam logic [31:0] MX [3] = '{32'h32, 32'h64, 32'hFA0};  // level, time, minimum limits
  logic        clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, irq, output_cut;
  logic        drive_running, flux_vector_mode, stop_command;
  logic        speed_deviation_fault, speed_deviation_alarm;
  logic [5:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [15:0] freq_reference, output_frequency, motor_speed, freq_command, slip;
  logic [2:0]  drive_action;
  int          errors, checks_done, n;
  // ---------------------------------------------------------------
  // Design and motor
  // ---------------------------------------------------------------
  speed_deviation_supervisor #(.TICK_CYCLES(TICK)) dut (.*);
  motor_model motor (.*);
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic stop_test;
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One Avalon access, held until wait request is seen low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk_sys);
      k++;
      if (k > 20) begin
        errors++;
        stop_test();
      end
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rdc(input string nm, input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge clk_sys);
  endtask
  // Counts cycles until a fault or alarm shows
  task automatic wait_flag;
    n = 0;
    while (speed_deviation_fault !== 1'b1 && speed_deviation_alarm !== 1'b1) begin
      settle(1);
      n++;
      if (n > 60) begin
        errors++;
        stop_test();
      end
    end
  endtask
  // ---------------------------------------------------------------
  // Clock and sequence
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    errors = 0;
    checks_done = 0;
    rd = $urandom(90811);
    {rst_n, avs_read, avs_write, drive_running, flux_vector_mode, stop_command} = '0;
    {avs_address, avs_writedata, freq_reference, slip} = '0;
    avs_byteenable = 4'hF;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 9; i++) rdc("reset value", RA[i], RV[i]);
    // limits: over maximum refused, maximum taken
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, RA[i + 1], MX[i] + 32'h1);
      rdc("over max", RA[i + 1], RV[i + 1]);
      rdc("refused flag", 6'h18, 32'h4);
      bus(1'b1, 6'h18, 32'h4);
      bus(1'b1, RA[i + 1], MX[i]);
      rdc("at max", RA[i + 1], MX[i]);
    end
    drive_running <= 1'b1;
    bus(1'b1, 6'h04, 32'h5);
    bus(1'b1, 6'h00, 32'h1);
    rdc("level frozen", 6'h04, 32'h32);
    rdc("select frozen", 6'h00, 32'h3);
    drive_running <= 1'b0;
    bus(1'b1, 6'h18, 32'h7);
    // stop methods, flux rejects brake and timer
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, 6'h00, 32'(s << 4) | 32'h3);
      stop_command <= 1'b1;
      settle(2);
      chk("stop action", {29'h0, SA[s]}, {29'h0, drive_action});
      stop_command <= 1'b0;
    end
    bus(1'b1, 6'h00, 32'h3);
    flux_vector_mode <= 1'b1;
    bus(1'b1, 6'h00, 32'h23);
    bus(1'b1, 6'h00, 32'h33);
    rdc("flux stop", 6'h00, 32'h3);
    // zero-speed methods with reference under minimum
    bus(1'b1, 6'h0C, 32'h64);
    freq_reference <= 16'h0032;
    for (int z = 0; z < 4; z++) begin
      bus(1'b1, 6'h00, 32'(z << 8) | 32'h3);
      settle(2);
      chk("zero cmd", (z == 0) ? 32'h32 : (z == 2) ? 32'h64 : 32'h0, {16'h0, freq_command});
      chk("zero cut", (z == 1) ? 32'h1 : 32'h0, {31'h0, output_cut});
    end
    flux_vector_mode <= 1'b0;
    bus(1'b1, 6'h0C, 32'h0);
    for (int i = 0; i < 6; i++) begin
      freq_reference <= 16'($urandom_range(1000, 0));
      slip <= 16'($urandom_range(200, 0));
      settle(2);
      rdc("deviation", 6'h20, {16'h0, slip});
    end
    // every select, wide band so encoder match holds
    bus(1'b1, 6'h14, 32'hC8);
    bus(1'b1, 6'h04, 32'hA);
    bus(1'b1, 6'h08, 32'h1);
    bus(1'b1, 6'h1C, 32'h3);
    freq_reference <= 16'h012C;
    for (int s = 0; s < 8; s++) begin
      bus(1'b1, 6'h00, 32'(s));
      bus(1'b1, 6'h18, 32'h7);
      slip <= 16'h0064;
      drive_running <= 1'b1;
      wait_flag();
      chk("persist", 32'h1, {31'h0, n >= TICK});
      chk("fault", {31'h0, (s % 4) != 3}, {31'h0, speed_deviation_fault});
      chk("alarm", {31'h0, (s % 4) == 3}, {31'h0, speed_deviation_alarm});
      chk("irq", 32'h1, {31'h0, irq});
      settle(2);
      chk("fault action", {29'h0, FA[s % 4]}, {29'h0, drive_action});
      drive_running <= 1'b0;
      slip <= 16'h0;
    end
    // threshold boundary: sixty tenths is not above ten percent of 600
    bus(1'b1, 6'h00, 32'h3);
    bus(1'b1, 6'h18, 32'h7);
    bus(1'b1, 6'h08, 32'h2);
    slip <= 16'h003C;
    drive_running <= 1'b1;
    settle(20);
    chk("at level", 32'h0, {31'h0, speed_deviation_alarm});
    // a short drop of the deviation restarts the two-unit timer
    slip <= 16'h003D;
    settle(6);
    slip <= 16'h0;
    settle(1);
    slip <= 16'h003D;
    settle(6);
    chk("restart", 32'h0, {31'h0, speed_deviation_alarm});
    wait_flag();
    bus(1'b1, 6'h1C, 32'h0);
    settle(1);
    chk("masked irq", 32'h0, {31'h0, irq});
    drive_running <= 1'b0;
    bus(1'b1, 6'h18, 32'h7);
    rdc("cleared", 6'h18, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
